//--- src/bt_pkg.sv
// Shared constants and types for the basic watchdog and stabilization timer
package bt_pkg;
    // Register addresses in the CPU register space
    localparam logic [7:0] CONTROL_ADDR = 8'hD3;
    localparam logic [7:0] COUNT_ADDR = 8'hFD;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] COUNT_RESET = 8'h00;
    // Control field layout
    localparam int WDT_KEY_HI = 7;
    localparam int WDT_KEY_LO = 4;
    localparam int SEL_HI = 3;
    localparam int SEL_LO = 2;
    localparam int CNT_CLR_BIT = 1;
    localparam int DIV_CLR_BIT = 0;
    localparam logic [3:0] WDT_DISABLE_KEY = 4'hA;
    // Stabilization ends on the carry out of this counter bit
    localparam int STAB_BIT = 4;
    // Divider ratios and the code that selects each
    localparam int DIV_WIDTH = 12;
    localparam logic [1:0] SEL_DIV4096 = 2'h0;
    localparam logic [1:0] SEL_DIV1024 = 2'h1;
    localparam logic [1:0] SEL_DIV128 = 2'h2;
    localparam logic [1:0] SEL_DIV16 = 2'h3;
    localparam logic [DIV_WIDTH-1:0] DIV4096_MASK = 12'hFFF;
    localparam logic [DIV_WIDTH-1:0] DIV1024_MASK = 12'h3FF;
    localparam logic [DIV_WIDTH-1:0] DIV128_MASK = 12'h07F;
    localparam logic [DIV_WIDTH-1:0] DIV16_MASK = 12'h00F;

    // Register bus request from the CPU
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_type;

    // Stabilization phase states
    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_STOP = 2'b01,
        ST_STAB = 2'b10
    } stab_state_type;
endpackage

//--- src/bt_prescaler.sv
// Free-running prescaler that produces the selected tick enable
`timescale 1ns/1ps
module bt_prescaler
    import bt_pkg::*;
#(
    parameter int WIDTH = DIV_WIDTH
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_resetn,
    // Control
    input wire logic i_clear,
    input wire logic i_run,
    input wire logic [1:0] i_select,
    // Tick
    output logic o_tick
);
    typedef struct packed {
        logic [WIDTH-1:0] count;
    } presc_state_type;

    presc_state_type state_r;
    presc_state_type state_nxt;
    logic [WIDTH-1:0] mask;

    // Ratio multiplexer: a tick when the low bits all reach one
    always_comb begin
        if (i_select == SEL_DIV4096) begin
            mask = DIV4096_MASK;
        end else if (i_select == SEL_DIV1024) begin
            mask = DIV1024_MASK;
        end else if (i_select == SEL_DIV128) begin
            mask = DIV128_MASK;
        end else begin
            mask = DIV16_MASK;
        end
    end

    assign o_tick = i_run && !i_clear && ((state_r.count & mask) == mask);

    // Counting stops while the oscillator is held off
    always_comb begin
        state_nxt = state_r;
        if (i_clear) begin
            state_nxt.count = '0;
        end else if (i_run) begin
            state_nxt.count = state_r.count + 1'b1;
        end
    end

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end
endmodule

//--- src/bt_counter.sv
// Eight-bit up counter with carry outputs
`timescale 1ns/1ps
module bt_counter
    import bt_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int TAP = STAB_BIT
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_resetn,
    // Control
    input wire logic i_clear,
    input wire logic i_tick,
    // Count and carries
    output logic [WIDTH-1:0] o_count,
    output logic o_overflow,
    output logic o_tap_carry
);
    typedef struct packed {
        logic [WIDTH-1:0] count;
    } cnt_state_type;

    cnt_state_type state_r;
    cnt_state_type state_nxt;

    assign o_count = state_r.count;
    // Carries are qualified by the tick that causes them
    assign o_overflow = i_tick && !i_clear && (&state_r.count);
    assign o_tap_carry = i_tick && !i_clear && (&state_r.count[TAP:0]);

    // Clear beats increment so a clear write is never undone
    always_comb begin
        state_nxt = state_r;
        if (i_clear) begin
            state_nxt.count = '0;
        end else if (i_tick) begin
            state_nxt.count = state_r.count + 1'b1;
        end
    end

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end
endmodule

//--- src/basic_watchdog_stabilization_timer.sv
// Basic timer: watchdog reset and oscillation stabilization release
// Functional notes
// - Counter clock from divider 4096/1024/128/16 mux.
// - Eight-bit up counter, readable, never writable.
// - Reset clears control: watchdog on, divide 4096.
// - Watchdog off only with upper nibble 1010.
// - Writing bit 1 clears the counter.
// - Writing bit 0 clears the frequency dividers.
// - Enabled watchdog resets chip on bit 7 overflow.
// - Reset selects CPU clock divided by 4096.
// - Stop release: 4096 after reset, else preset selection.
// - Bit 4 carry ends stabilization, releases CPU clock.
`timescale 1ns/1ps
module basic_watchdog_stabilization_timer
    import bt_pkg::*;
#(
    parameter int COUNT_WIDTH = 8,
    // Counter bit whose carry ends stabilization; lowered only to shorten simulation
    parameter int STAB_TAP = STAB_BIT
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_resetn,
    // CPU register access
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    output logic o_reg_hit,
    // Power management
    input wire logic i_stop_enter,
    input wire logic i_wake_int,
    // System outputs
    output logic o_watchdog_reset,
    output logic o_cpu_clock_enable,
    output logic o_stab_done,
    output logic o_divider_clear
);
    typedef struct packed {
        logic [7:0] control;
        stab_state_type phase;
        logic force_slow;
        logic wdt_reset;
        logic stab_done;
        logic [7:0] rdata;
        logic hit;
    } top_state_type;

    top_state_type state_r;
    top_state_type state_nxt;
    reg_req_type req;
    logic wr_control;
    logic cnt_clear;
    logic div_clear;
    logic div_run;
    logic tick;
    logic [1:0] sel_eff;
    logic [COUNT_WIDTH-1:0] count;
    logic overflow;
    logic stab_carry;
    logic wdt_enabled;

    // Request bundle from the plain ports
    assign req = '{wr: i_reg_wr, rd: i_reg_rd, addr: i_reg_addr, wdata: i_reg_wdata};
    assign wr_control = req.wr && (req.addr == CONTROL_ADDR);

    // Clear bits act on the write itself and are also stored in control, so they read back
    assign cnt_clear = wr_control && req.wdata[CNT_CLR_BIT];
    assign div_clear = wr_control && req.wdata[DIV_CLR_BIT];
    assign o_divider_clear = div_clear;

    // Any nibble but the key leaves the watchdog armed
    assign wdt_enabled = state_r.control[WDT_KEY_HI:WDT_KEY_LO] != WDT_DISABLE_KEY;

    // Oscillator is held off in stop mode, so nothing counts
    assign div_run = state_r.phase != ST_STOP;

    // After a reset wake the slow ratio is forced until stable
    assign sel_eff = state_r.force_slow ? SEL_DIV4096 : state_r.control[SEL_HI:SEL_LO];

    bt_prescaler #(
        .WIDTH(DIV_WIDTH)
    ) u_prescaler (
        .i_clock(i_clock),
        .i_resetn(i_resetn),
        .i_clear(div_clear),
        .i_run(div_run),
        .i_select(sel_eff),
        .o_tick(tick)
    );

    bt_counter #(
        .WIDTH(COUNT_WIDTH),
        .TAP(STAB_TAP)
    ) u_counter (
        .i_clock(i_clock),
        .i_resetn(i_resetn),
        .i_clear(cnt_clear),
        .i_tick(tick),
        .o_count(count),
        .o_overflow(overflow),
        .o_tap_carry(stab_carry)
    );

    // Register file, stop-mode sequencer and watchdog reset
    always_comb begin
        state_nxt = state_r;
        state_nxt.wdt_reset = 1'b0;
        state_nxt.stab_done = 1'b0;
        state_nxt.hit = 1'b0;
        state_nxt.rdata = 8'h00;

        // Control write stores select and key; count has no write path
        if (wr_control) begin
            state_nxt.control = req.wdata;
        end

        // Read decode, unmapped addresses read zero with no hit
        if (req.rd && (req.addr == CONTROL_ADDR)) begin
            state_nxt.rdata = state_r.control;
            state_nxt.hit = 1'b1;
        end else if (req.rd && (req.addr == COUNT_ADDR)) begin
            state_nxt.rdata = 8'(count);
            state_nxt.hit = 1'b1;
        end else if (wr_control) begin
            state_nxt.hit = 1'b1;
        end

        // Watchdog only bites during normal running
        if ((state_r.phase == ST_RUN) && wdt_enabled && overflow) begin
            state_nxt.wdt_reset = 1'b1;
        end

        case (state_r.phase)
            ST_RUN: begin
                if (i_stop_enter) begin
                    state_nxt.phase = ST_STOP;
                end
            end
            ST_STOP: begin
                if (i_wake_int) begin
                    state_nxt.phase = ST_STAB;
                end
            end
            ST_STAB: begin
                if (stab_carry) begin
                    state_nxt.phase = ST_RUN;
                    state_nxt.stab_done = 1'b1;
                    state_nxt.force_slow = 1'b0;
                end
            end
            default: begin
                state_nxt.phase = ST_RUN;
            end
        endcase
    end

    // Reset counts as a stop release with the slow ratio forced
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            state_r.control <= CONTROL_RESET;
            state_r.phase <= ST_STAB;
            state_r.force_slow <= 1'b1;
            state_r.wdt_reset <= 1'b0;
            state_r.stab_done <= 1'b0;
            state_r.rdata <= 8'h00;
            state_r.hit <= 1'b0;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Outputs
    assign o_reg_rdata = state_r.rdata;
    assign o_reg_hit = state_r.hit;
    assign o_watchdog_reset = state_r.wdt_reset;
    assign o_stab_done = state_r.stab_done;
    assign o_cpu_clock_enable = state_r.phase == ST_RUN;
endmodule

//--- test/bt_properties.sv
// Port checks for the basic timer
`timescale 1ns/1ps
module bt_properties
    import bt_pkg::*;
(
    // Watched ports
    input wire logic i_clock, i_resetn, i_reg_wr, i_reg_rd, i_stop_enter, i_wake_int,
    input wire logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata,
    input wire logic o_reg_hit, o_watchdog_reset, o_cpu_clock_enable, o_stab_done,
    input wire logic o_divider_clear
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_resetn);
    // Decoded accesses; a count read two cycles after a write clearing both counter and divider must see zero
    wire logic ctl_wr = i_reg_wr && i_reg_addr == CONTROL_ADDR;
    wire logic cnt_rd = i_reg_rd && i_reg_addr == COUNT_ADDR;
    wire logic mapped = i_reg_addr == CONTROL_ADDR || i_reg_addr == COUNT_ADDR;
    AST_DIV_CLEAR: assert property (o_divider_clear == (ctl_wr && i_reg_wdata[0]))
        else $error("divider clear mismatch");
    AST_COUNT_CLEAR: assert property (ctl_wr && i_reg_wdata[1:0] == 2'h3 ##2 cnt_rd
        |=> o_reg_rdata == 8'h00) else $error("count not cleared");
    AST_RD_HIT: assert property (i_reg_rd && mapped |=> o_reg_hit)
        else $error("read not acknowledged");
    AST_FD_NO_WRITE: assert property (i_reg_wr && !i_reg_rd && i_reg_addr == COUNT_ADDR
        |=> !o_reg_hit) else $error("count write accepted");
    AST_UNMAPPED: assert property (i_reg_rd && !mapped |=> o_reg_rdata == 8'h00 && !o_reg_hit)
        else $error("unmapped read answered");
    AST_WD_PULSE: assert property ($rose(o_watchdog_reset) |=> !o_watchdog_reset)
        else $error("reset pulse too long");
    AST_GATE_RELEASE: assert property ($rose(o_cpu_clock_enable) |-> o_stab_done)
        else $error("clock released without done");
    AST_STOP_GATE: assert property (i_stop_enter && o_cpu_clock_enable
        |=> !o_cpu_clock_enable [*8]) else $error("clock not gated in stop");
    // Main scenarios reached
    COV_WD: cover property (o_watchdog_reset);
    COV_STAB: cover property (o_stab_done);
    COV_WAKE: cover property (i_wake_int && !o_cpu_clock_enable);
endmodule
bind basic_watchdog_stabilization_timer bt_properties chk (.*);

//--- test/bt_cpu_model.sv
// CPU-side register access model for the basic timer
`timescale 1ns/1ps
module bt_cpu_model
    import bt_pkg::*;
(
    // Clock and answer
    input wire logic i_clock,
    input wire logic [7:0] i_rdata,
    input wire logic i_hit,
    // Request
    output logic o_wr,
    output logic o_rd,
    output logic [7:0] o_addr,
    output logic [7:0] o_wdata
);
    logic hit;
    // Idle bus; released lines show the inverse so stale values never match
    initial begin
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_addr = 8'h00;
        o_wdata = 8'h00;
    end
    // Software keeps the watchdog fed or keyed off through these writes
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_clock);
        o_wr = 1'b1;
        o_addr = a;
        o_wdata = d;
        @(negedge i_clock);
        o_wr = 1'b0;
        o_addr = ~a;
        o_wdata = ~d;
        hit = i_hit;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge i_clock);
        o_rd = 1'b1;
        o_addr = a;
        @(negedge i_clock);
        o_rd = 1'b0;
        o_addr = ~a;
        d = i_rdata;
        hit = i_hit;
    endtask
endmodule

//--- test/tb_basic_watchdog_stabilization_timer.sv
// Testbench for the basic watchdog and stabilization timer
`timescale 1ns/1ps
module tb_basic_watchdog_stabilization_timer;
    import bt_pkg::*;
    logic i_clock, i_resetn, i_stop_enter, i_wake_int, i_reg_wr, i_reg_rd, o_reg_hit;
    logic o_watchdog_reset, o_cpu_clock_enable, o_stab_done, o_divider_clear;
    logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata, d;
    int miscompares = 0, cmp_count = 0, n, seed = 32'hAA5953F6;
    int div[4] = '{4096, 1024, 128, 16};
    // A lower stabilization tap keeps the post-reset wait inside the cycle budget
    localparam int TAP_BIT = 2;
    basic_watchdog_stabilization_timer #(.STAB_TAP(TAP_BIT)) uut (.*);
    bt_cpu_model cpu (.i_clock, .i_rdata(o_reg_rdata), .i_hit(o_reg_hit), .o_wr(i_reg_wr),
        .o_rd(i_reg_rd), .o_addr(i_reg_addr), .o_wdata(i_reg_wdata));
    // Reference model: divider, counter and phase (0 run, 1 stop, 2 stabilize)
    int m_div = 0, m_cnt = 0, m_ctl = 0, m_phase = 2, m_ratio = 4096;
    int m_reads[$];
    bit m_slow = 1'b1, m_wr, m_tick;
    always @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            m_div = 0;
            m_cnt = 0;
            m_ctl = 0;
            m_phase = 2;
            m_slow = 1'b1;
        end else begin
            m_wr = i_reg_wr && i_reg_addr == CONTROL_ADDR;
            m_ratio = m_slow ? div[0] : div[(m_ctl / 4) % 4];
            m_tick = m_phase != 1 && !(m_wr && i_reg_wdata[0]) && m_div % m_ratio == m_ratio - 1;
            // Count reads see the value held before this edge
            if (i_reg_rd && i_reg_addr == COUNT_ADDR) m_reads.push_back(m_cnt);
            if (m_wr && i_reg_wdata[0]) m_div = 0;
            else if (m_phase != 1) m_div = (m_div + 1) % 4096;
            if (m_phase == 0 && i_stop_enter) begin
                m_phase = 1;
            end else if (m_phase == 1 && i_wake_int) begin
                m_phase = 2;
            end else if (m_phase == 2 && m_tick && !(m_wr && i_reg_wdata[1])
                && m_cnt % (2 << TAP_BIT) == (2 << TAP_BIT) - 1) begin
                m_phase = 0;
                m_slow = 1'b0;
            end
            if (m_wr && i_reg_wdata[1]) m_cnt = 0;
            else if (m_tick) m_cnt = (m_cnt + 1) % 256;
            if (m_wr) m_ctl = i_reg_wdata;
        end
    end
    initial begin
        i_clock = 1'b0;
        forever #2 i_clock = ~i_clock;
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("FAIL %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict;
        if (miscompares == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Bounded wait for a reset or done pulse; running out ends the run
    task automatic wait_ev(input bit wd, input int lim, output int k);
        for (k = 1; k <= lim; k++) begin
            @(negedge i_clock);
            if ((wd ? o_watchdog_reset : o_stab_done) === 1'b1) return;
        end
        check(8'h1, 8'h0);
        print_verdict();
    endtask
    initial begin
        #400000;
        miscompares++;
        print_verdict();
    end
    initial begin
        i_resetn = 1'b0;
        i_stop_enter = 1'b0;
        i_wake_int = 1'b0;
        repeat (2) @(negedge i_clock);
        i_resetn = 1'b1;
        cpu.rd(CONTROL_ADDR, d);
        check(d, CONTROL_RESET);
        check({7'h0, o_cpu_clock_enable}, 8'h0);
        // Post-reset interval is 2 << TAP_BIT ticks of divide-4096 despite any select
        wait_ev(0, 40000, n);
        check(8'(n >= 32756 && n <= 32776), 8'h1);
        @(negedge i_clock);
        check({7'h0, o_cpu_clock_enable}, 8'h1);
        // Every select code: clear, wait three and a half ticks, expect three
        for (int s = 0; s < 4; s++) begin
            cpu.wr(CONTROL_ADDR, {WDT_DISABLE_KEY, 2'(s), 2'h3});
            cpu.rd(COUNT_ADDR, d);
            check(d, 8'h0);
            check(d, 8'(m_reads.pop_front()));
            repeat (3 * div[s] + div[s] / 2) @(negedge i_clock);
            cpu.rd(COUNT_ADDR, d);
            check(d, 8'h3);
            check(d, 8'(m_reads.pop_front()));
            cpu.rd(CONTROL_ADDR, d);
            check(d, {WDT_DISABLE_KEY, 2'(s), 2'h3});
        end
        n = 0;
        repeat (5000) begin
            @(negedge i_clock);
            n += o_watchdog_reset;
        end
        check(8'(n), 8'h0);
        d = 8'($random(seed));
        if (d[7:4] == WDT_DISABLE_KEY) d[7:4] = 4'h5;
        repeat (4) begin
            cpu.wr(CONTROL_ADDR, {d[7:4], SEL_DIV16, 2'h2});
            repeat (3000) begin
                @(negedge i_clock);
                n += o_watchdog_reset;
            end
        end
        check(8'(n), 8'h0);
        cpu.wr(CONTROL_ADDR, {d[7:4], SEL_DIV16, 2'h3});
        wait_ev(1, 4200, n);
        check(8'(n >= 4090 && n <= 4102), 8'h1);
        cpu.wr(COUNT_ADDR, 8'hFF);
        check({7'h0, cpu.hit}, 8'h0);
        cpu.rd(COUNT_ADDR, d);
        check(d, 8'h0);
        check(d, 8'(m_reads.pop_front()));
        d = 8'($random(seed));
        if (d == CONTROL_ADDR || d == COUNT_ADDR) d = 8'h00;
        cpu.rd(d, d);
        check({d, cpu.hit} == 9'h0, 8'h1);
        // Stop, then wake by interrupt at the preset divide-16 rate
        cpu.wr(CONTROL_ADDR, {WDT_DISABLE_KEY, SEL_DIV16, 2'h3});
        i_stop_enter = 1'b1;
        @(negedge i_clock);
        i_stop_enter = 1'b0;
        repeat (20) @(negedge i_clock);
        check({7'h0, o_cpu_clock_enable}, 8'h0);
        i_wake_int = 1'b1;
        @(negedge i_clock);
        i_wake_int = 1'b0;
        wait_ev(0, 600, n);
        check(8'(n >= 122 && n <= 132), 8'h1);
        check({7'h0, o_cpu_clock_enable}, 8'(m_phase == 0));
        print_verdict();
    end
endmodule
